/* File: hdl/uart_enhanced_register_bank.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_bank_consts.svh"

// What this block does
// [R1] Enable register masks four basic interrupt sources
// [R2] FIFO receive interrupt needs FIFO and enable
// [R3] Receive interrupt raised at trigger level
// [R4] Receive interrupt drops below trigger level
// [R5] Status code tracks trigger together with output
// [R6] Data ready sets when character enters FIFO
// [R7] Data ready clears only when FIFO empty
// [R8] Extended bits work only with enhanced bit
// [R9] Enhanced bit gates extended fields and fraction
// [R10] Divisor bytes at zero, one; fraction four bits
// [R11] Enhanced registers need the access key
module uart_enhanced_register_bank (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire uart_bank_pkg::host_req_t req,
    input wire uart_bank_pkg::uart_stat_t stat,
    output logic [7:0] rdData,
    output logic irq,
    output uart_bank_pkg::uart_cfg_t cfg
);
    import uart_bank_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic bank_t bankOf(input logic [7:0] line_control_reg);
        if (line_control_reg == `UB_ENH_KEY) begin
            bankOf = BANK_ENH; // [R11]
        end else if (line_control_reg[`UB_LCR_DIVEN]) begin
            bankOf = BANK_DIVISOR; // [R10]
        end else begin
            bankOf = BANK_COMPAT;
        end
    endfunction

    function automatic logic [7:0] gateExt(input logic [7:0] value, input logic [7:0] extMask,
                                           input logic enh);
        gateExt = enh ? value : (value & ~extMask); // [R8] [R9]
    endfunction

    function automatic logic [6:0] tableTrig(input logic [1:0] sel);
        case (sel)
            2'h0: tableTrig = `UB_RXTRIG_T0;
            2'h1: tableTrig = `UB_RXTRIG_T1;
            2'h2: tableTrig = `UB_RXTRIG_T2;
            default: tableTrig = `UB_RXTRIG_T3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    bank_state_t s;
    bank_state_t next_s;
    bank_t bank;
    logic enh;
    logic fifoMode;
    logic [6:0] rxTrigNow;
    logic dataReady;
    logic trigHit;
    logic [3:0] intCode;
    logic txReady;
    logic lineErr;
    logic idVisible;
    logic [7:0] isrValue;
    logic [7:0] lsrValue;
    logic wrStb;
    logic rdStb;

    assign bank = bankOf(s.cfg.lineCtrl);
    assign enh = s.cfg.enhFunc[`UB_EFR_ENH];
    assign fifoMode = s.cfg.fifoCtrl[`UB_FCR_FIFOEN] && s.cfg.intEnable[`UB_IER_RXDATA]; // [R2]
    assign lineErr = |(stat.lineFlags & `UB_LINE_ERR_MASK);
    assign txReady = stat.lineFlags[`UB_LSR_THRE] && !s.txAck;
    assign idVisible = (s.cfg.divisor == 16'h0000);
    assign wrStb = ce && req.sel && req.wr;
    assign rdStb = ce && req.sel && req.rd;

    always_comb begin
        if (s.cfg.featCtrl[5:4] == `UB_TRIG_TABLE_PROG) begin
            rxTrigNow = s.progRxTrig;
        end else begin
            rxTrigNow = tableTrig(s.cfg.fifoCtrl[7:6]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive readiness and interrupt source

    uart_rx_ready rxReady (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .rxLevel(stat.rxLevel),
        .rxPush(stat.rxPush),
        .trigLevel(rxTrigNow),
        .fifoMode(fifoMode),
        .dataReady(dataReady),
        .trigHit(trigHit)
    );

    uart_int_source intSource (
        .enable(s.cfg.intEnable[3:0]),
        .lineErr(lineErr),
        .rxHit(trigHit),
        .txReady(txReady),
        .modemChg(stat.modemChg),
        .code(intCode)
    );

    assign isrValue = {{2{s.cfg.fifoCtrl[`UB_FCR_FIFOEN]}}, 2'b00, intCode}; // [R5]
    assign lsrValue = {stat.lineFlags, dataReady}; // [R6]

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and reads

    always_comb begin
        next_s = s;
        // FIFO reset bits act for one cycle only
        next_s.cfg.fifoCtrl = s.cfg.fifoCtrl & ~`UB_FCR_PULSE_MASK;
        if (!stat.lineFlags[`UB_LSR_THRE]) begin
            next_s.txAck = 1'b0;
        end
        next_s.irq = (intCode != `UB_ISR_NONE); // [R3] [R4] [R5]

        if (wrStb) begin
            if (req.addr == `UB_A_LCR) begin
                next_s.cfg.lineCtrl = req.wdata;
            end else if (bank == BANK_ENH) begin
                if (req.addr == `UB_A_TRG) begin
                    if (s.cfg.featCtrl[`UB_FEATURE_CONTROL_TXSEL]) begin
                        next_s.cfg.txTrigger = req.wdata[6:0];
                    end else begin
                        next_s.progRxTrig = req.wdata[6:0];
                    end
                end else if (req.addr == `UB_A_FEATURE_CONTROL) begin
                    next_s.cfg.featCtrl = req.wdata; // [R11]
                end else if (req.addr == `UB_A_EFR) begin
                    next_s.cfg.enhFunc = req.wdata; // [R11]
                end else if (req.addr >= `UB_A_FLOW_BASE) begin
                    next_s.cfg.flowChars[req.addr[1:0]] = req.wdata; // [R11]
                end
            end else if (bank == BANK_DIVISOR && req.addr == `UB_A_DIVLO) begin
                next_s.cfg.divisor[7:0] = req.wdata; // [R10]
            end else if (bank == BANK_DIVISOR && req.addr == `UB_A_DIVHI) begin
                next_s.cfg.divisor[15:8] = req.wdata; // [R10]
            end else if (bank == BANK_DIVISOR && req.addr == `UB_A_FRAC) begin
                if (enh) begin
                    next_s.cfg.fracDiv = req.wdata[3:0]; // [R9] [R10]
                end
            end else if (bank == BANK_COMPAT && req.addr == `UB_A_HOLD) begin
                next_s.txAck = 1'b0;
            end else if (bank == BANK_COMPAT && req.addr == `UB_A_IER) begin
                next_s.cfg.intEnable = gateExt(req.wdata, `UB_IER_ENH_MASK, enh); // [R1] [R9]
            end else if (bank != BANK_ENH && req.addr == `UB_A_ISR) begin
                next_s.cfg.fifoCtrl = gateExt(req.wdata, `UB_FCR_ENH_MASK, enh); // [R9]
            end else if (req.addr == `UB_A_MCR) begin
                next_s.cfg.modemCtrl = gateExt(req.wdata, `UB_MCR_ENH_MASK, enh); // [R9]
            end
        end

        if (rdStb) begin
            next_s.rdData = `UB_RST_BYTE;
            if (req.addr == `UB_A_LCR) begin
                next_s.rdData = s.cfg.lineCtrl;
            end else if (bank == BANK_ENH) begin
                if (req.addr == `UB_A_TRG) begin
                    next_s.rdData = {1'b0, s.cfg.featCtrl[`UB_FEATURE_CONTROL_TXSEL] ? stat.txLevel : stat.rxLevel};
                end else if (req.addr == `UB_A_FEATURE_CONTROL) begin
                    next_s.rdData = s.cfg.featCtrl; // [R11]
                end else if (req.addr == `UB_A_EFR) begin
                    next_s.rdData = s.cfg.enhFunc; // [R11]
                end else if (req.addr >= `UB_A_FLOW_BASE) begin
                    next_s.rdData = s.cfg.flowChars[req.addr[1:0]]; // [R11]
                end
            end else if (bank == BANK_DIVISOR && req.addr == `UB_A_DIVLO) begin
                next_s.rdData = idVisible ? `UB_REV_ID : s.cfg.divisor[7:0]; // [R10]
            end else if (bank == BANK_DIVISOR && req.addr == `UB_A_DIVHI) begin
                next_s.rdData = idVisible ? `UB_DEV_ID : s.cfg.divisor[15:8]; // [R10]
            end else if (bank == BANK_DIVISOR && req.addr == `UB_A_FRAC) begin
                next_s.rdData = enh ? ({4'h0, s.cfg.fracDiv} & `UB_FRAC_MASK) : `UB_RST_BYTE; // [R9] [R10]
            end else if (bank == BANK_COMPAT && req.addr == `UB_A_IER) begin
                next_s.rdData = gateExt(s.cfg.intEnable, `UB_IER_ENH_MASK, enh); // [R8]
            end else if (bank != BANK_ENH && req.addr == `UB_A_ISR) begin
                next_s.rdData = isrValue; // [R5]
                // Reading a transmit-ready source acknowledges it
                if (intCode == `UB_ISR_TXRDY) begin
                    next_s.txAck = 1'b1;
                end
            end else if (req.addr == `UB_A_MCR) begin
                next_s.rdData = gateExt(s.cfg.modemCtrl, `UB_MCR_ENH_MASK, enh); // [R8]
            end else if (req.addr == `UB_A_LSR) begin
                next_s.rdData = lsrValue; // [R6] [R7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
            s.progRxTrig <= `UB_RST_TRIG;
            s.cfg.rxTrigger <= `UB_RST_TRIG;
            s.cfg.txTrigger <= `UB_RST_TRIG;
        end else if (ce) begin
            s <= next_s;
            s.cfg.rxTrigger <= rxTrigNow;
        end
    end

    assign rdData = s.rdData;
    assign irq = s.irq;
    assign cfg = s.cfg;
endmodule
`default_nettype wire

/* File: include/uart_bank_consts.svh */
`ifndef UART_BANK_CONSTS_SVH
`define UART_BANK_CONSTS_SVH

// Register addresses, compatible bank
`define UB_A_HOLD 3'h0
`define UB_A_IER 3'h1
`define UB_A_ISR 3'h2
`define UB_A_LCR 3'h3
`define UB_A_MCR 3'h4
`define UB_A_LSR 3'h5
// Register addresses, divisor bank
`define UB_A_DIVLO 3'h0
`define UB_A_DIVHI 3'h1
`define UB_A_FRAC 3'h2
// Register addresses, enhanced bank
`define UB_A_TRG 3'h0
`define UB_A_FEATURE_CONTROL 3'h1
`define UB_A_EFR 3'h2
`define UB_A_FLOW_BASE 3'h4

// Bank selection
`define UB_ENH_KEY 8'hbf
`define UB_LCR_DIVEN 7

// Bit positions
`define UB_EFR_ENH 4
`define UB_FCR_FIFOEN 0
`define UB_IER_RXDATA 0
`define UB_IER_TXEMPTY 1
`define UB_IER_LINE 2
`define UB_IER_MODEM 3
`define UB_FEATURE_CONTROL_TXSEL 7
`define UB_LSR_THRE 5

// Field masks
`define UB_IER_ENH_MASK 8'hf0
`define UB_FCR_ENH_MASK 8'h30
`define UB_MCR_ENH_MASK 8'he0
`define UB_FRAC_MASK 8'h0f
`define UB_FCR_PULSE_MASK 8'h06
`define UB_LINE_ERR_MASK 7'h0f

// Interrupt source codes
`define UB_ISR_LINE 4'h6
`define UB_ISR_RXDATA 4'h4
`define UB_ISR_TXRDY 4'h2
`define UB_ISR_MODEM 4'h0
`define UB_ISR_NONE 4'h1

// Receive trigger table and programmable table select
`define UB_RXTRIG_T0 7'h08
`define UB_RXTRIG_T1 7'h10
`define UB_RXTRIG_T2 7'h38
`define UB_RXTRIG_T3 7'h3c
`define UB_TRIG_TABLE_PROG 2'h3

// Reset values
`define UB_RST_BYTE 8'h00
`define UB_RST_TRIG 7'h01
`define UB_ZERO_LEVEL 7'h00

// Identification, values arbitrary
`define UB_REV_ID 8'h01
`define UB_DEV_ID 8'h5a

`endif

/* File: include/uart_bank_pkg.sv */
package uart_bank_pkg;

    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [6:0] rxLevel;
        logic [6:0] txLevel;
        logic rxPush;
        logic [7:1] lineFlags;
        logic modemChg;
    } uart_stat_t;

    typedef struct packed {
        logic [15:0] divisor;
        logic [3:0] fracDiv;
        logic [7:0] lineCtrl;
        logic [7:0] fifoCtrl;
        logic [7:0] modemCtrl;
        logic [7:0] intEnable;
        logic [7:0] enhFunc;
        logic [7:0] featCtrl;
        logic [6:0] rxTrigger;
        logic [6:0] txTrigger;
        logic [3:0][7:0] flowChars;
    } uart_cfg_t;

    typedef enum logic [2:0] {
        BANK_COMPAT = 3'b001,
        BANK_DIVISOR = 3'b010,
        BANK_ENH = 3'b100
    } bank_t;

    typedef struct packed {
        logic dataReady;
        logic trigHit;
    } rx_state_t;

    typedef struct packed {
        uart_cfg_t cfg;
        logic [6:0] progRxTrig;
        logic txAck;
        logic [7:0] rdData;
        logic irq;
    } bank_state_t;

endpackage

/* File: hdl/uart_rx_ready.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_bank_consts.svh"

module uart_rx_ready
    import uart_bank_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic [6:0] rxLevel,
    input wire logic rxPush,
    input wire logic [6:0] trigLevel,
    input wire logic fifoMode,
    output logic dataReady,
    output logic trigHit
);
    rx_state_t s;
    rx_state_t next_s;

    always_comb begin
        next_s = s;
        // Set on a push wins over the empty clear
        if (rxPush) begin
            next_s.dataReady = 1'b1; // [R6]
        end else if (rxLevel == `UB_ZERO_LEVEL) begin
            next_s.dataReady = 1'b0; // [R7]
        end
        if (fifoMode) begin
            next_s.trigHit = (rxLevel >= trigLevel); // [R2] [R3] [R4]
        end else begin
            next_s.trigHit = (rxLevel != `UB_ZERO_LEVEL);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign dataReady = s.dataReady;
    assign trigHit = s.trigHit;
endmodule
`default_nettype wire

/* File: hdl/uart_int_source.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_bank_consts.svh"

module uart_int_source (
    input wire logic [3:0] enable,
    input wire logic lineErr,
    input wire logic rxHit,
    input wire logic txReady,
    input wire logic modemChg,
    output logic [3:0] code
);
    // Highest pending enabled source wins
    always_comb begin
        if (enable[`UB_IER_LINE] && lineErr) begin
            code = `UB_ISR_LINE; // [R1]
        end else if (enable[`UB_IER_RXDATA] && rxHit) begin
            code = `UB_ISR_RXDATA; // [R5]
        end else if (enable[`UB_IER_TXEMPTY] && txReady) begin
            code = `UB_ISR_TXRDY; // [R1]
        end else if (enable[`UB_IER_MODEM] && modemChg) begin
            code = `UB_ISR_MODEM; // [R1]
        end else begin
            code = `UB_ISR_NONE;
        end
    end
endmodule
`default_nettype wire

/* File: tb/uart_bank_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module uart_bank_sva (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire uart_bank_pkg::host_req_t req,
    input wire uart_bank_pkg::uart_stat_t stat,
    input wire logic [7:0] rdData,
    input wire logic irq,
    input wire uart_bank_pkg::uart_cfg_t cfg
);
    import uart_bank_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic fifoMode;
    logic hit;
    logic keyOn;
    logic lsrRd;
    logic acc;
    assign fifoMode = cfg.fifoCtrl[0] && cfg.intEnable[0];
    assign hit = stat.rxLevel >= cfg.rxTrigger;
    assign keyOn = cfg.lineCtrl == 8'hbf;
    assign acc = ce && req.sel;
    assign lsrRd = acc && req.rd && req.addr == 3'h5 && !cfg.lineCtrl[7];
    ////////////////////////////////////////
    sequence hold_hit_s;
        (ce && fifoMode && hit)[*2];
    endsequence
    sequence hold_low_s;
        (ce && fifoMode && !hit && cfg.intEnable[3:1] == 3'h0)[*2];
    endsequence
    sequence push_read_s;
        (ce && stat.rxPush) ##1 lsrRd;
    endsequence
    ////////////////////////////////////////
    irq_rise_a: assert property (hold_hit_s |=> irq)
        else $error("irq missing at trigger");
    irq_fall_a: assert property (hold_low_s |=> !irq)
        else $error("irq stays below trigger");
    irq_mask_a: assert property ((ce && cfg.intEnable[3:0] == 4'h0)[*2] |=> !irq)
        else $error("irq with all sources masked");
    non_fifo_a: assert property ((ce && !cfg.fifoCtrl[0] && cfg.intEnable[3:0] == 4'h1
        && stat.rxLevel != 7'h00)[*2] |=> irq) else $error("non fifo rx irq missing");
    ready_set_a: assert property (push_read_s |=> rdData[0])
        else $error("data ready not set");
    ready_hold_a: assert property ((lsrRd && stat.rxLevel != 7'h00) ##1 (lsrRd && rdData[0]) |=> rdData[0])
        else $error("data ready cleared early");
    frac_zero_a: assert property (acc && req.rd && req.addr == 3'h2 && cfg.lineCtrl[7] && !keyOn
        |=> rdData[7:4] == 4'h0) else $error("fraction upper bits set");
    ier_gate_a: assert property (acc && req.wr && req.addr == 3'h1 && !cfg.lineCtrl[7] && !cfg.enhFunc[4]
        |=> cfg.intEnable == ($past(req.wdata) & 8'h0f)) else $error("enable gating wrong");
    enh_lock_a: assert property (acc && req.wr && req.addr == 3'h2 && !keyOn |=> $stable(cfg.enhFunc))
        else $error("enhanced register written without key");
    enh_write_a: assert property (acc && req.wr && req.addr == 3'h2 && keyOn
        |=> cfg.enhFunc == $past(req.wdata)) else $error("enhanced register not written");
endmodule
`default_nettype wire

/* File: tb/uart_rx_fifo_model.sv */
`timescale 1ns/10ps
`default_nettype none
module uart_rx_fifo_model (
    input wire logic clk_sys,
    input wire logic pushReq,
    input wire logic popReq,
    output var logic [6:0] rxLevel,
    output var logic rxPush
);
    initial begin
        rxLevel = 7'h00;
        rxPush = 1'b0;
    end
    // Push pulse and level step land on the same edge
    always @(posedge clk_sys) begin
        rxPush <= pushReq && rxLevel < 7'h40;
        if (pushReq && rxLevel < 7'h40) begin
            rxLevel <= rxLevel + 7'h01;
        end else if (popReq && rxLevel != 7'h00) begin
            rxLevel <= rxLevel - 7'h01;
        end
    end
endmodule
`default_nettype wire

/* File: tb/uart_enhanced_register_bank_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uart_bank_consts.svh"
module uart_enhanced_register_bank_tb;
    import uart_bank_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    host_req_t req = '0;
    logic pushReq = 1'b0;
    logic popReq = 1'b0;
    logic modemChg = 1'b0;
    logic [6:0] rxLevel;
    logic rxPush;
    logic [7:0] rdData;
    logic irq;
    uart_cfg_t cfg;
    uart_stat_t stat;
    int mismatches = 0;
    int totalChecks = 0;
    int lvl = 0;
    logic [7:0] v;
    logic [7:0] r;
    assign stat = {rxLevel, 7'h00, rxPush, 7'h00, modemChg};
    uart_enhanced_register_bank dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .req(req), .stat(stat),
        .rdData(rdData), .irq(irq), .cfg(cfg));
    uart_rx_fifo_model far (.clk_sys(clk_sys), .pushReq(pushReq), .popReq(popReq), .rxLevel(rxLevel),
        .rxPush(rxPush));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////
    function automatic logic expIrq(input int n);
        return n >= `UB_RXTRIG_T0;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        totalChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{sel: 1'b1, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys);
        req = '0;
    endtask
    task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        req = '{sel: 1'b1, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        req = '0;
        check(rdData, exp, "read");
    endtask
    task automatic move(input logic up, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            pushReq = up;
            popReq = !up;
            @(negedge clk_sys);
            pushReq = 1'b0;
            popReq = 1'b0;
            lvl += up ? 1 : -1;
        end
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic irqChk(input logic exp);
        repeat (3) @(negedge clk_sys);
        check({7'h00, irq}, {7'h00, exp}, "irq");
    endtask
    task automatic done(input string name);
        $display("test done: %s", name);
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #200us;
        mismatches++;
        wrapUp();
    end
    initial begin
        void'($urandom(32'h1f3cd651));
        repeat (16) @(negedge clk_sys);
        srst = 1'b0;
        rdChk(3'h1, 8'h00);
        wr(3'h3, 8'h80);
        rdChk(3'h0, `UB_REV_ID);
        r = 8'($urandom());
        wr(3'h0, r);
        wr(3'h1, r | 8'h01);
        rdChk(3'h0, r);
        rdChk(3'h1, r | 8'h01);
        wr(3'h2, 8'hff);
        rdChk(3'h2, 8'h00);
        done("divisor");
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        rdChk(3'h2, 8'h10);
        for (int i = 4; i < 8; i++) begin
            v = 8'($urandom());
            wr(3'(i), v);
            rdChk(3'(i), v);
        end
        wr(3'h3, 8'h80);
        wr(3'h2, 8'hff);
        rdChk(3'h2, 8'h0f);
        wr(3'h3, 8'h00);
        wr(3'h1, 8'hff);
        rdChk(3'h1, 8'hff);
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h1, 8'hff);
        rdChk(3'h1, 8'h0f);
        wr(3'h4, 8'hff);
        rdChk(3'h4, 8'h1f);
        wr(3'h2, 8'h10);
        wr(3'h3, 8'hbf);
        rdChk(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        done("gating");
        wr(3'h2, 8'h01);
        wr(3'h1, 8'h01);
        move(1'b1, 7);
        irqChk(1'b0);
        rdChk(3'h2, 8'hc1);
        move(1'b1, 1);
        irqChk(1'b1);
        rdChk(3'h2, 8'hc4);
        rdChk(3'h5, 8'h01);
        move(1'b0, 1);
        irqChk(1'b0);
        rdChk(3'h2, 8'hc1);
        wr(3'h2, 8'h00);
        irqChk(1'b1);
        wr(3'h2, 8'h01);
        irqChk(1'b0);
        done("trigger");
        wr(3'h1, 8'h08);
        modemChg = 1'b1;
        irqChk(1'b1);
        rdChk(3'h2, 8'hc0);
        wr(3'h1, 8'h00);
        irqChk(1'b0);
        modemChg = 1'b0;
        wr(3'h1, 8'h01);
        done("mask");
        ce = 1'b0;
        wr(3'h1, 8'h0f);
        ce = 1'b1;
        rdChk(3'h1, 8'h01);
        done("clock enable");
        for (int i = 0; i < 40; i++) begin
            if (lvl == 0 || (lvl < 20 && $urandom_range(1) == 1)) begin
                move(1'b1, $urandom_range(1, 3));
            end else begin
                move(1'b0, 1);
            end
            check({7'h00, irq}, {7'h00, expIrq(lvl)}, "irq");
            rdChk(3'h5, {7'h00, lvl != 0});
        end
        @(negedge clk_sys);
        pushReq = 1'b1;
        @(negedge clk_sys);
        pushReq = 1'b0;
        req = '{sel: 1'b1, rd: 1'b1, wr: 1'b0, addr: 3'h5, wdata: 8'h00};
        repeat (3) @(negedge clk_sys);
        req = '0;
        lvl += 1;
        check(rdData, 8'h01, "ready after push");
        move(1'b0, lvl);
        rdChk(3'h5, 8'h00);
        done("random");
        srst = 1'b1;
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        rdChk(3'h1, 8'h00);
        done("reset");
        wrapUp();
    end
endmodule
bind uart_enhanced_register_bank uart_bank_sva chk (.clk_sys(clk_sys), .srst(srst), .ce(ce), .req(req),
    .stat(stat), .rdData(rdData), .irq(irq), .cfg(cfg));
`default_nettype wire
